// ---- shared/aqs_defs.vh ----
// Register map, field layout, modes and counts of the queue scan control
`ifndef AQS_DEFS_VH
`define AQS_DEFS_VH
`define AQS_PG_REG 4'h0
`define AQS_PG_CCW 4'h1
`define AQS_PG_RES 4'h2
`define AQS_A_CTL0 8'h00
`define AQS_A_Q1 8'h04
`define AQS_A_Q2 8'h08
`define AQS_A_STAT 8'h0C
`define AQS_M_DIS 3'h0
`define AQS_M_SWSS 3'h1
`define AQS_M_ITSS 3'h2
`define AQS_M_SWCS 3'h3
`define AQS_M_GATE 3'h4
`define AQS_M_PERC 3'h5
`define AQS_F_QPR 6:0
`define AQS_F_MODE 2:0
`define AQS_F_SSE 3
`define AQS_F_IVL 12:8
`define AQS_F_BQ2 22:16
`define AQS_F_FLAGS 5:0
`define AQS_F_LAST1 13:8
`define AQS_F_LAST2 21:16
`define AQS_F_RUN 25:24
`define AQS_F_PAU 27:26
`define AQS_F_GATE 28
`define AQS_F_CHAN 5:0
`define AQS_F_IST 7:6
`define AQS_F_PAUSE 9
`define AQS_EOQ_CHAN 6'h3F
`define AQS_TBL_DEPTH 7'h40
`define AQS_QPR_RST 7'h04
`define AQS_IVL_RST 5'h07
`define AQS_BQ2_RST 7'h40
`define AQS_TMR_STAGES 17
`define AQS_TMR_MIN 5'h07
`define AQS_TMR_MAX 5'h11
`define AQS_CONV_QCLKS 6'h0E
`define AQS_SAMP_BASE 6'h02
`endif

// ---- rtl/aqs_clkgen.v ----
// Converter clock prescaler producing a one-cycle enable
`timescale 1ns/1ps
module aqs_clkgen (
  input wire hclk,
  input wire hresetn,
  input wire [6:0] prescale,
  output reg tick
);
  reg [6:0] cnt;

  // Period is prescale + 1 system clocks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 7'h00;
      tick <= 1'b0;
    end else if (cnt >= prescale) begin
      cnt <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule

// ---- rtl/aqs_timer.v ----
// Periodic/interval timer: binary divider on the converter clock
`timescale 1ns/1ps
`include "aqs_defs.vh"
module aqs_timer #(
  parameter STAGES = `AQS_TMR_STAGES
) (
  input wire hclk,
  input wire hresetn,
  input wire tick,
  input wire hold,
  input wire clr,
  input wire [4:0] sel,
  output wire expire
);
  reg [STAGES-1:0] cnt;
  wire [STAGES-1:0] lim;
  wire [4:0] s;

  assign s = (sel < `AQS_TMR_MIN) ? `AQS_TMR_MIN :
             (sel > `AQS_TMR_MAX) ? `AQS_TMR_MAX : sel;
  genvar b;
  generate
    for (b = 0; b < STAGES; b = b + 1) begin : g_lim
      assign lim[b] = (b < s);
    end
  endgenerate

  assign expire = tick & ~hold & ~clr & (cnt == lim);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= {STAGES{1'b0}};
    end else if (hold | clr) begin
      cnt <= {STAGES{1'b0}};
    end else if (tick) begin
      if (cnt == lim) begin
        cnt <= {STAGES{1'b0}};
      end else begin
        cnt <= cnt + {{(STAGES-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ---- rtl/aqs_top.v ----
// Queue scan control: bus slave, tables, queue sequencer and timer use
`timescale 1ns/1ps
`include "aqs_defs.vh"
module aqs_top #(
  parameter [5:0] CONV_QCLKS = `AQS_CONV_QCLKS
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  input wire gate_pin,
  input wire stop_req,
  input wire debug_req,
  input wire [9:0] conv_result,
  output reg conv_start,
  output reg [5:0] conv_channel,
  output wire conv_busy
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  function is_tm;
    input [2:0] m;
    begin
      is_tm = (m == `AQS_M_ITSS) | (m == `AQS_M_PERC);
    end
  endfunction

  reg gate_s1;
  reg gate_s2;
  reg gate_s3;
  reg gate_lvl;
  reg dp_rd;
  reg dp_wr;
  reg rd_done;
  reg [11:0] dp_addr;
  reg [31:0] rdmux;
  reg [6:0] prescale;
  reg [2:0] mode1;
  reg [2:0] mode2;
  reg sse1;
  reg sse2;
  reg [4:0] ivl1;
  reg [4:0] ivl2;
  reg [6:0] bq2;
  reg [5:0] flags;
  reg [5:0] lastp1;
  reg [5:0] lastp2;
  reg [6:0] ptr1;
  reg [6:0] ptr2;
  reg [1:0] run;
  reg [1:0] pau;
  reg [1:0] st;
  reg eng_q;
  reg [5:0] eng_idx;
  reg eng_pause;
  reg [5:0] cnt;
  reg tmr_fired;
  reg [9:0] ccw_mem [0:63];
  reg [9:0] res_mem [0:63];
  integer i;

  wire qtick;
  wire tmr_exp;

  // Gate pin: three stages, level taken when the last two agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
      gate_s3 <= 1'b0;
      gate_lvl <= 1'b0;
    end else begin
      gate_s1 <= gate_pin;
      gate_s2 <= gate_s1;
      gate_s3 <= gate_s2;
      if (gate_s2 == gate_s3) begin
        gate_lvl <= gate_s2;
      end
    end
  end

  // AHB-Lite slave: writes zero wait, reads one wait state
  wire acc = hsel & hready & htrans[1] & (hsize == 3'h2);
  wire wr_en = dp_wr;
  wire pg_reg = (dp_addr[11:8] == `AQS_PG_REG);
  wire wr_ctl0 = wr_en & pg_reg & (dp_addr[7:0] == `AQS_A_CTL0);
  wire wr_q1 = wr_en & pg_reg & (dp_addr[7:0] == `AQS_A_Q1) & ~stop_req;
  wire wr_q2 = wr_en & pg_reg & (dp_addr[7:0] == `AQS_A_Q2) & ~stop_req;
  wire wr_stat = wr_en & pg_reg & (dp_addr[7:0] == `AQS_A_STAT);
  wire wr_ccw = wr_en & (dp_addr[11:8] == `AQS_PG_CCW);
  wire wr_res = wr_en & (dp_addr[11:8] == `AQS_PG_RES);
  wire [2:0] nmode = hwdata[`AQS_F_MODE];
  wire chg1 = wr_q1 & (nmode != mode1);
  wire chg2 = wr_q2 & (nmode != mode2);

  assign hreadyout = ~dp_rd | rd_done;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_rd <= 1'b0;
      dp_wr <= 1'b0;
      rd_done <= 1'b0;
      dp_addr <= 12'h000;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      dp_rd <= acc & ~hwrite;
      dp_wr <= acc & hwrite;
      rd_done <= 1'b0;
      if (acc) begin
        dp_addr <= {haddr[11:2], 2'b00};
      end
    end else if (dp_rd & ~rd_done) begin
      hrdata <= rdmux;
      rd_done <= 1'b1;
    end
  end

  always @* begin
    rdmux = 32'h00000000;
    case (dp_addr[11:8])
      `AQS_PG_REG: begin
        case (dp_addr[7:0])
          `AQS_A_CTL0: rdmux[`AQS_F_QPR] = prescale;
          `AQS_A_Q1: begin
            rdmux[`AQS_F_MODE] = mode1;
            rdmux[`AQS_F_SSE] = sse1;
            rdmux[`AQS_F_IVL] = ivl1;
          end
          `AQS_A_Q2: begin
            rdmux[`AQS_F_MODE] = mode2;
            rdmux[`AQS_F_SSE] = sse2;
            rdmux[`AQS_F_IVL] = ivl2;
            rdmux[`AQS_F_BQ2] = bq2;
          end
          `AQS_A_STAT: begin
            rdmux[`AQS_F_FLAGS] = flags;
            rdmux[`AQS_F_LAST1] = lastp1;
            rdmux[`AQS_F_LAST2] = lastp2;
            rdmux[`AQS_F_RUN] = run;
            rdmux[`AQS_F_PAU] = pau;
            rdmux[`AQS_F_GATE] = gate_lvl;
          end
          default: rdmux = 32'h00000000;
        endcase
      end
      `AQS_PG_CCW: rdmux[9:0] = ccw_mem[dp_addr[7:2]];
      `AQS_PG_RES: rdmux[9:0] = res_mem[dp_addr[7:2]];
      default: rdmux = 32'h00000000;
    endcase
  end

  // Queue boundaries
  wire [6:0] end1 = (bq2 > `AQS_TBL_DEPTH) ? `AQS_TBL_DEPTH : bq2;
  wire gated = (mode1 == `AQS_M_GATE);

  // Trigger sources
  wire use1 = (mode1 == `AQS_M_PERC) | ((mode1 == `AQS_M_ITSS) & sse1);
  wire use2 = (mode2 == `AQS_M_PERC) | ((mode2 == `AQS_M_ITSS) & sse2);
  wire sw1 = (mode1 == `AQS_M_SWCS) | ((mode1 == `AQS_M_SWSS) & sse1);
  wire sw2 = (mode2 == `AQS_M_SWCS) | ((mode2 == `AQS_M_SWSS) & sse2);
  wire tm1 = tmr_exp & use1;
  wire tm2 = tmr_exp & use2;
  wire start1 = ~run[0] & (gated ? gate_lvl : (sw1 | tm1));
  wire start2 = ~run[1] & (sw2 | tm2);
  wire ovr1 = tm1 & run[0];
  wire ovr2 = tm2 & run[1];

  // Command fetch for the queue chosen by priority
  wire sq = ~run[0];
  wire [6:0] sptr = sq ? ptr2 : ptr1;
  wire [6:0] send = sq ? `AQS_TBL_DEPTH : end1;
  wire [9:0] cw = ccw_mem[sptr[5:0]];
  wire at_eoq = (sptr >= send) |
                (cw[`AQS_F_CHAN] == `AQS_EOQ_CHAN);
  wire go = st[0] & ~debug_req & ~stop_req & (run[0] | run[1]);
  wire [5:0] samp = `AQS_SAMP_BASE << cw[`AQS_F_IST];

  // Conversion end, abort and queue 1 preemption of queue 2
  wire fin = st[1] & qtick & (cnt == 6'h01);
  wire abort2 = st[1] & eng_q & run[0] & ~fin;
  wire kill = stop_req | (eng_q ? chg2 : chg1) | abort2;
  wire done = fin & ~kill;

  assign conv_busy = st[1];

  // Conversion engine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ST_IDLE;
      eng_q <= 1'b0;
      eng_idx <= 6'h00;
      eng_pause <= 1'b0;
      cnt <= 6'h00;
      conv_start <= 1'b0;
      conv_channel <= 6'h00;
    end else begin
      conv_start <= 1'b0;
      case (st)
        ST_IDLE: begin
          if (go & ~at_eoq) begin
            st <= ST_CONV;
            eng_q <= sq;
            eng_idx <= sptr[5:0];
            eng_pause <= cw[`AQS_F_PAUSE];
            cnt <= CONV_QCLKS + samp;
            conv_channel <= cw[`AQS_F_CHAN];
            conv_start <= 1'b1;
          end
        end
        ST_CONV: begin
          if (kill | done) begin
            st <= ST_IDLE;
          end else if (qtick) begin
            cnt <= cnt - 6'h01;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Command and result tables
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 64; i = i + 1) begin
        ccw_mem[i] <= 10'h000;
        res_mem[i] <= 10'h000;
      end
    end else begin
      if (wr_ccw) begin
        ccw_mem[dp_addr[7:2]] <= hwdata[9:0];
      end
      if (done) begin
        res_mem[eng_idx] <= conv_result;
      end else if (wr_res) begin
        res_mem[dp_addr[7:2]] <= hwdata[9:0];
      end
    end
  end

  // Control registers, flags and queue state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale <= `AQS_QPR_RST;
      mode1 <= `AQS_M_DIS;
      mode2 <= `AQS_M_DIS;
      sse1 <= 1'b0;
      sse2 <= 1'b0;
      ivl1 <= `AQS_IVL_RST;
      ivl2 <= `AQS_IVL_RST;
      bq2 <= `AQS_BQ2_RST;
      flags <= 6'h00;
      lastp1 <= 6'h00;
      lastp2 <= 6'h00;
      ptr1 <= 7'h00;
      ptr2 <= `AQS_BQ2_RST;
      run <= 2'b00;
      pau <= 2'b00;
    end else begin
      if (wr_stat) begin
        flags <= flags & ~hwdata[`AQS_F_FLAGS];
      end
      if (wr_ctl0) begin
        prescale <= hwdata[`AQS_F_QPR];
      end
      if (wr_q1) begin
        mode1 <= nmode;
        sse1 <= hwdata[`AQS_F_SSE];
        ivl1 <= hwdata[`AQS_F_IVL];
      end
      if (wr_q2) begin
        mode2 <= nmode;
        sse2 <= hwdata[`AQS_F_SSE];
        ivl2 <= hwdata[`AQS_F_IVL];
        bq2 <= hwdata[`AQS_F_BQ2];
      end
      if (start1) begin
        run[0] <= 1'b1;
        pau[0] <= 1'b0;
        if (~pau[0]) begin
          ptr1 <= 7'h00;
        end
      end
      if (start2) begin
        run[1] <= 1'b1;
        pau[1] <= 1'b0;
        if (~pau[1]) begin
          ptr2 <= bq2;
        end
      end
      if (ovr1) begin
        flags[2] <= 1'b1;
      end
      if (ovr2) begin
        flags[5] <= 1'b1;
      end
      if (go & at_eoq) begin
        if (~sq) begin
          flags[0] <= 1'b1;
          ptr1 <= 7'h00;
          if (gated) begin
            if (flags[0]) begin
              flags[2] <= 1'b1;
            end
          end else begin
            run[0] <= 1'b0;
            pau[0] <= 1'b0;
            if (~is_tm(mode1) | (mode1 == `AQS_M_ITSS)) begin
              sse1 <= 1'b0;
            end
          end
        end else begin
          flags[3] <= 1'b1;
          run[1] <= 1'b0;
          pau[1] <= 1'b0;
          ptr2 <= bq2;
          if (~is_tm(mode2) | (mode2 == `AQS_M_ITSS)) begin
            sse2 <= 1'b0;
          end
        end
      end
      if (done) begin
        if (~eng_q) begin
          lastp1 <= eng_idx;
          ptr1 <= ptr1 + 7'h01;
          if (gated) begin
            if (~gate_lvl) begin
              run[0] <= 1'b0;
              flags[1] <= 1'b1;
            end
          end else if (eng_pause) begin
            run[0] <= 1'b0;
            pau[0] <= 1'b1;
            flags[1] <= 1'b1;
          end
        end else begin
          lastp2 <= eng_idx;
          ptr2 <= ptr2 + 7'h01;
          if (eng_pause) begin
            run[1] <= 1'b0;
            pau[1] <= 1'b1;
            flags[4] <= 1'b1;
          end
        end
      end
      if (abort2) begin
        ptr2 <= bq2;
      end
      if (chg1) begin
        run[0] <= 1'b0;
        pau[0] <= 1'b0;
      end
      if (chg2) begin
        run[1] <= 1'b0;
        pau[1] <= 1'b0;
      end
      if (stop_req) begin
        mode1 <= `AQS_M_DIS;
        mode2 <= `AQS_M_DIS;
        sse1 <= 1'b0;
        sse2 <= 1'b0;
        ivl1 <= 5'h00;
        ivl2 <= 5'h00;
        bq2 <= 7'h00;
        run <= 2'b00;
        pau <= 2'b00;
      end
    end
  end

  // Timer control: hold, one-time clear and debug freeze
  wire tmr_hold = ~(use1 | use2) | stop_req |
                  (debug_req & (~st[1] | ~tmr_fired));
  wire tmr_pulse = (chg1 & is_tm(nmode)) |
                   (chg2 & is_tm(nmode) & ~is_tm(mode1));

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_fired <= 1'b0;
    end else if (tmr_hold | tmr_pulse) begin
      tmr_fired <= 1'b0;
    end else if (tmr_exp) begin
      tmr_fired <= 1'b1;
    end
  end

  aqs_clkgen u_clkgen (
    .hclk(hclk),
    .hresetn(hresetn),
    .prescale(prescale),
    .tick(qtick)
  );

  aqs_timer #(
    .STAGES(`AQS_TMR_STAGES)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(qtick),
    .hold(tmr_hold),
    .clr(tmr_pulse),
    .sel(use1 ? ivl1 : ivl2),
    .expire(tmr_exp)
  );
endmodule

// ---- verif/aqs_gate_src.sv ----
// Far-side model: external source of the queue 1 gate level
`timescale 1ns/1ps
module aqs_gate_src (
  input wire hclk,
  input wire open_req,
  output logic gate_pin
);
  logic lag;
  initial lag = 1'b0;
  initial gate_pin = 1'b0;
  // Level follows the request two edges late, high opens the gate
  always @(posedge hclk) begin
    lag <= open_req;
    gate_pin <= lag;
  end
endmodule

// ---- verif/aqs_top_assertions.sv ----
// Port-level checker for the queue scan control block
`timescale 1ns/1ps
module aqs_top_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  input wire gate_pin,
  input wire stop_req,
  input wire debug_req,
  input wire [9:0] conv_result,
  input wire conv_start,
  input wire [5:0] conv_channel,
  input wire conv_busy
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take;
    hsel && hready && htrans[1] && hsize == 3'h2;
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd_wait;
    s_take ##0 !hwrite |=> s_rd_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_nowait;
    s_take ##0 hwrite |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_start_busy;
    conv_start |-> conv_busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not busy");
  property p_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("starts adjacent");
  property p_eoq;
    conv_start |-> conv_channel != 6'h3F;
  endproperty
  a_eoq: assert property (p_eoq) else $error("end marker converted");
  property p_stop;
    stop_req [*3] |-> !conv_busy;
  endproperty
  a_stop: assert property (p_stop) else $error("busy in stop");
  property p_debug;
    debug_req [*3] |-> !conv_start;
  endproperty
  a_debug: assert property (p_debug) else $error("start in debug");
  property p_chan_hold;
    !conv_start |-> $stable(conv_channel);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
endmodule
bind aqs_top aqs_top_checker chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .gate_pin(gate_pin),
  .stop_req(stop_req), .debug_req(debug_req), .conv_result(conv_result),
  .conv_start(conv_start), .conv_channel(conv_channel),
  .conv_busy(conv_busy));

// ---- verif/tb.sv ----
// Self-checking bench for the queue scan control block
`timescale 1ns/1ps
`include "aqs_defs.vh"
module tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, open_req = 0;
  logic stop_req = 0, debug_req = 0, rs;
  logic [31:0] haddr = 0, hwdata = 0, rd, rq;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [9:0] conv_result = 0;
  logic [5:0] ch [4];
  logic [5:0] seen [$];
  int t_st [$];
  int n_fail = 0, tests_run = 0, cyc = 0, n_st = 0, blen = 0, bcnt = 0;
  int n0, n1;
  wire hreadyout, hresp, conv_start, conv_busy, gate_pin;
  wire [31:0] hrdata;
  wire [5:0] conv_channel;
  always #50 hclk = ~hclk;
  aqs_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .gate_pin(gate_pin), .stop_req(stop_req),
    .debug_req(debug_req), .conv_result(conv_result),
    .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_busy(conv_busy));
  aqs_gate_src gate_u (.hclk(hclk), .open_req(open_req),
    .gate_pin(gate_pin));
  always @(negedge hclk) begin
    rs = hreadyout;
    rq = hrdata;
  end
  // Converter stand-in and monitor of conversion starts and lengths
  always @(posedge hclk) begin
    cyc++;
    conv_result <= {4'hA, conv_channel};
    if (conv_start === 1'b1) begin
      seen.push_back(conv_channel);
      t_st.push_back(cyc);
      n_st++;
    end
    if (conv_busy === 1'b1)
      bcnt++;
    else if (bcnt != 0) begin
      blen = bcnt;
      bcnt = 0;
    end
  end
  task automatic results();
    $display("Counts: %0d checks, %0d errors", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(string nm);
    n_fail++;
    $display("Error %s expected event seen timeout", nm);
    results();
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    int k;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    for (int p = 0; p < 2; p++) begin
      for (k = 0; k < 20; k++) begin
        @(posedge hclk);
        if (rs === 1'b1)
          break;
      end
      if (k == 20)
        tmo("bus");
      if (p == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    rd = rq;
  endtask
  task automatic rdc(string nm, logic [31:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic wait_st(int n, int lim);
    for (int k = 0; k < lim && n_st < n; k++)
      @(posedge hclk);
    if (n_st < n)
      tmo("starts");
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge hclk);
  endtask
  initial begin
    void'($urandom(32'hEBC7));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ctl0", `AQS_A_CTL0, 32'h4);
    rdc("q1", `AQS_A_Q1, 32'h700);
    rdc("q2", `AQS_A_Q2, 32'h400700);
    rdc("stat", `AQS_A_STAT, 32'h0);
    rdc("unmapped", 32'h300, 32'h0);
    for (int i = 8; i < 16; i++) begin
      n0 = $urandom;
      bus(1'b1, 32'h100 + 4 * i, n0);
      rdc("ccw", 32'h100 + 4 * i, n0 & 32'h3FF);
    end
    bus(1'b1, `AQS_A_CTL0, 32'h1);
    for (int i = 0; i < 4; i++) begin
      ch[i] = 6'($urandom_range(62));
      bus(1'b1, 32'h100 + 4 * i, {22'h0, i == 1, 3'h0, ch[i]});
    end
    bus(1'b1, 32'h110, 32'h3F);
    bus(1'b1, `AQS_A_Q1, 32'h704);
    open_req <= 1'b1;
    wait_st(9, 3000);
    for (int i = 0; i < 9; i++)
      chk("gated order", ch[i % 4], seen[i]);
    chk("conv length", 1, blen >= 30 && blen <= 34);
    bus(1'b0, `AQS_A_STAT, 32'h0);
    chk("gated running", 32'h3, {rd[28], rd[24]});
    chk("gated flags", 32'h5, rd & 32'h7);
    open_req <= 1'b0;
    for (n0 = 0; n0 < 100; n0++) begin
      bus(1'b0, `AQS_A_STAT, 32'h0);
      if (rd[24] === 1'b0)
        break;
    end
    if (n0 == 100)
      tmo("gate stop");
    chk("pause on close", 1, rd[1]);
    chk("last pointer", (n_st - 1) % 4, rd[13:8]);
    for (int i = 0; i < 4; i++)
      rdc("result", 32'h200 + 4 * i, {4'hA, ch[i]});
    bus(1'b1, `AQS_A_STAT, 32'h3F);
    seen.delete();
    n0 = n_st;
    open_req <= 1'b1;
    wait_st(n0 + 1, 500);
    chk("reopen entry", ch[0], seen[0]);
    open_req <= 1'b0;
    bus(1'b1, `AQS_A_Q1, 32'h0);
    bus(1'b1, `AQS_A_STAT, 32'h3F);
    seen.delete();
    t_st.delete();
    n0 = n_st;
    bus(1'b1, `AQS_A_Q1, 32'h705);
    wait_st(n0 + 5, 3000);
    for (int i = 0; i < 5; i++)
      chk("periodic order", ch[i % 4], seen[i]);
    chk("pause wait", 1, t_st[2] - t_st[1] > 100);
    chk("interval", 256, t_st[4] - t_st[2]);
    bus(1'b0, `AQS_A_STAT, 32'h0);
    chk("periodic flags", 32'h3, rd & 32'h7);
    stop_req <= 1'b1;
    idle(10);
    stop_req <= 1'b0;
    bus(1'b0, `AQS_A_Q1, 32'h0);
    chk("stop clears mode", 32'h0, rd);
    rdc("stop clears q2", `AQS_A_Q2, 32'h0);
    n0 = n_st;
    idle(600);
    chk("held after stop", n0, n_st);
    bus(1'b1, `AQS_A_Q2, 32'h400000);
    bus(1'b1, `AQS_A_Q1, 32'h705);
    debug_req <= 1'b1;
    idle(600);
    chk("debug freeze", n0, n_st);
    debug_req <= 1'b0;
    n1 = cyc;
    wait_st(n0 + 1, 1000);
    n1 = t_st[$] - n1;
    chk("debug restart", 1, n1 >= 256 && n1 <= 280);
    bus(1'b1, `AQS_A_Q1, 32'h702);
    n0 = n_st;
    idle(600);
    chk("single waits", n0, n_st);
    bus(1'b1, `AQS_A_Q1, 32'h70A);
    wait_st(n0 + 1, 1000);
    bus(1'b1, `AQS_A_Q1, 32'h0);
    seen.delete();
    n0 = n_st;
    bus(1'b1, `AQS_A_Q2, 32'h20709);
    wait_st(n0 + 2, 500);
    idle(100);
    chk("q2 order", {ch[3], ch[2]}, {seen[1], seen[0]});
    chk("q2 single once", n0 + 2, n_st);
    rdc("q2 sse cleared", `AQS_A_Q2, 32'h20701);
    bus(1'b0, `AQS_A_STAT, 32'h0);
    chk("q2 complete", 32'h1, rd[5:3]);
    results();
  end
endmodule
